// File: cis_chan_intr.sv
// Purpose: Interrupt state logic of one channel with an AHB-Lite register port.
// Assumes: All inputs synchronous to core_clk; event inputs are one-cycle pulses.
// Notes: Zero-wait-state slave; hresp is always OKAY.
//
// Contract
// RULE_01 - Interrupt software only in state five.
// RULE_02 - Disable or activate in state five cancels.
// RULE_03 - Active enabled idle: poll, block, never interrupt.
// RULE_04 - Active enabled queued: poll, test-I/O collects.
// RULE_05 - Activate, acknowledge, unblocked context switch set active.
// RULE_06 - Any reset clears active, enabled, requests.
// RULE_07 - Non-reset completion raises a request.
// RULE_08 - Further completions queue; flag means one-plus.
// RULE_09 - Asynchronous controller status also raises request.
// RULE_10 - Host issues enable during initial program load.
// RULE_11 - Disable removes exactly one pending request.
// RULE_12 - Acknowledge only on own context switch.
// RULE_13 - Host blocks all interrupts globally.
// RULE_14 - Instructions return condition code all zeros.
// RULE_15 - Active while disabled still polls and blocks.
// RULE_16 - Active never interrupts, even winning poll.
// RULE_17 - Deactivate restores interrupting and stops blocking.
// RULE_18 - Inactive channel polls only when enabled requesting.
// RULE_19 - Active disabled polls, blocks, never interrupts.
// RULE_20 - Acknowledge makes active; invalid events change nothing.

module cis_chan_intr #(
  parameter int PEND_W = cis_pkg::PEND_W_DEF
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Channel and bus resets
  input wire logic chan_rst,
  input wire logic bus_rst,
  // Completion events
  input wire logic io_complete,
  input wire logic io_rst_op,
  input wire logic async_status,
  input wire logic tio_collect,
  // Host context switch
  input wire logic ctx_ack,
  input wire logic ctx_unblock,
  input wire logic cpu_blocked,
  // Interrupt bus poll
  input wire logic poll_win,
  output logic poll_req,
  output logic intr_req,
  // Flags
  output logic active_flag,
  output logic enabled_flag,
  output logic requesting_flag
);

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  logic wr_pend_q;
  logic [7:0] waddr_q;
  logic addr_hit;
  logic [31:0] status_w;

  assign addr_hit = hsel && hready && htrans[1];

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wr_pend_q <= 1'b0;
      waddr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_hit && hwrite;
      waddr_q <= haddr[7:0];
    end
  end

  // Answers within the same cycle, so the bus never stalls.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Read data is captured at the address phase, so it shows the state of that edge.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hrdata <= cis_pkg::RDATA_RST;
    end else if (addr_hit && !hwrite && (haddr[7:0] == cis_pkg::ADDR_STATUS)) begin
      hrdata <= status_w;
    end else begin
      hrdata <= cis_pkg::RDATA_RST;
    end
  end

  // ****************************************************************
  // Event decode
  // ****************************************************************
  logic cmd_wr;
  logic ev_enable;
  logic ev_disable;
  logic ev_activate;
  logic ev_deactivate;
  logic ev_request;
  logic ev_ack;
  logic ack_bad;
  logic clr_wr;
  logic rst_all;
  logic state5;

  assign rst_all = sys_rst || chan_rst || bus_rst; // RULE_06
  assign cmd_wr = wr_pend_q && (waddr_q == cis_pkg::ADDR_CMD);
  assign clr_wr = wr_pend_q && (waddr_q == cis_pkg::ADDR_CLEAR) && hwdata[0];
  assign ev_enable = cmd_wr && (hwdata[2:0] == cis_pkg::INSTR_ENABLE);
  assign ev_disable = cmd_wr && (hwdata[2:0] == cis_pkg::INSTR_DISABLE);
  assign ev_activate = cmd_wr && (hwdata[2:0] == cis_pkg::INSTR_ACTIVATE);
  assign ev_deactivate = cmd_wr && (hwdata[2:0] == cis_pkg::INSTR_DEACTIVATE);
  assign ev_request = (io_complete && !io_rst_op) || async_status; // RULE_07 RULE_09
  assign state5 = enabled_flag && !active_flag && requesting_flag;
  assign ev_ack = ctx_ack && state5; // RULE_12
  assign ack_bad = ctx_ack && !state5; // RULE_20

  // ****************************************************************
  // Flags
  // ****************************************************************
  logic active_d;
  logic enabled_d;
  logic req_d;
  logic [PEND_W-1:0] pend_count;
  logic pend_nonzero;
  logic [3:0] cc_q;
  logic invalid_q;

  // Activation wins over a deactivate that lands in the same cycle.
  assign active_d = (active_flag && !ev_deactivate) || ev_activate || ctx_unblock
                    || ev_ack; // RULE_05 RULE_20
  assign enabled_d = (enabled_flag && !ev_disable) || ev_enable;

  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      active_flag <= 1'b0; // RULE_06
    end else begin
      active_flag <= active_d; // RULE_05
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      enabled_flag <= 1'b0; // RULE_06
    end else begin
      enabled_flag <= enabled_d;
    end
  end

  // Only the count is kept; a cycle with any disable, acknowledge or test-I/O posts one status.
  cis_pend_cnt #(
    .W(PEND_W)
  ) u_pend (
    .core_clk(core_clk),
    .clr(rst_all),
    .inc(ev_request), // RULE_08
    .dec(ev_disable || ev_ack || tio_collect), // RULE_11 RULE_04
    .count_q(pend_count),
    .nonzero_q(pend_nonzero)
  );

  assign requesting_flag = pend_nonzero; // RULE_08

  // Next request flag for the poll decision, mirroring the counter.
  always_comb begin
    req_d = pend_nonzero;
    if (rst_all) begin
      req_d = 1'b0;
    end else if (ev_request && !(ev_disable || ev_ack || tio_collect)) begin
      req_d = 1'b1;
    end else if (!ev_request && (ev_disable || ev_ack || tio_collect)) begin
      req_d = (pend_count > {{(PEND_W-1){1'b0}}, 1'b1});
    end
  end

  // ****************************************************************
  // Poll and interrupt
  // ****************************************************************
  logic state5_d;

  assign state5_d = enabled_d && !active_d && req_d && !rst_all;

  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      poll_req <= 1'b0;
    end else begin
      poll_req <= active_d || state5_d; // RULE_03 RULE_15 RULE_18 RULE_19 RULE_17
    end
  end

  // The host still gates delivery with its block and unblock instructions.
  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      intr_req <= 1'b0;
    end else begin
      intr_req <= state5_d && poll_win && !cpu_blocked; // RULE_01 RULE_02 RULE_16 RULE_13
    end
  end

  // ****************************************************************
  // Condition code and error flag
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cc_q <= cis_pkg::CC_RST;
    end else if (ev_enable || ev_disable || ev_activate || ev_deactivate) begin
      cc_q <= cis_pkg::CC_OK; // RULE_14
    end
  end

  // An invalid acknowledge in the clearing cycle still sets the flag.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      invalid_q <= 1'b0;
    end else if (ack_bad) begin
      invalid_q <= 1'b1; // RULE_20
    end else if (clr_wr) begin
      invalid_q <= 1'b0;
    end
  end

  always_comb begin
    status_w = 32'h0000_0000;
    status_w[cis_pkg::ST_ACTIVE] = active_flag;
    status_w[cis_pkg::ST_ENABLED] = enabled_flag;
    status_w[cis_pkg::ST_REQUESTING] = requesting_flag;
    status_w[cis_pkg::ST_POLL] = poll_req;
    status_w[cis_pkg::ST_INTR] = intr_req;
    status_w[cis_pkg::ST_STATE_LO +: 3] = cis_pkg::state_num(enabled_flag, active_flag,
                                                             requesting_flag);
    status_w[cis_pkg::ST_CC_LO +: 4] = cc_q;
    status_w[cis_pkg::ST_INVALID] = invalid_q;
    status_w[cis_pkg::ST_COUNT_LO +: PEND_W] = pend_count;
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  logic [2:0] cur_state;
  logic no_dec;
  assign cur_state = cis_pkg::state_num(enabled_flag, active_flag, requesting_flag);
  assign no_dec = !(ev_disable || ev_ack || tio_collect);

  a_intr_only_s5: assert property ( // RULE_01
    intr_req |-> (cur_state == cis_pkg::STATE_INTR) && $past(poll_win) && !$past(cpu_blocked))
    else $error("interrupt outside state five");

  a_s5_cancel: assert property ( // RULE_02
    (state5 && (ev_disable || ev_activate)) |=> !intr_req)
    else $error("interrupt delivered after disable or activate");

  a_active_polls: assert property ( // RULE_19
    active_flag |-> poll_req)
    else $error("active channel not polling");

  a_idle_nopoll: assert property ( // RULE_18
    (!active_flag && !state5) |-> !poll_req)
    else $error("inactive channel polling outside state five");

  a_active_noint: assert property ( // RULE_16
    active_flag |-> !intr_req)
    else $error("active channel interrupted");

  a_reset_clears: assert property ( // RULE_06
    (chan_rst || bus_rst) |=> !active_flag && !enabled_flag && !requesting_flag && !poll_req)
    else $error("flags survive reset");

  a_req_counts: assert property ( // RULE_07
    (io_complete && !io_rst_op && !async_status && no_dec && !rst_all && !(&pend_count))
    |=> (pend_count == $past(pend_count) + {{(PEND_W-1){1'b0}}, 1'b1}) && requesting_flag)
    else $error("completion not counted");

  a_rstop_ignored: assert property ( // RULE_07
    (io_complete && io_rst_op && !async_status && no_dec && !rst_all)
    |=> pend_count == $past(pend_count))
    else $error("reset-channel completion counted");

  a_disable_one: assert property ( // RULE_11
    (ev_disable && !ev_request && !ev_ack && !tio_collect && pend_nonzero && !rst_all)
    |=> (pend_count == $past(pend_count) - {{(PEND_W-1){1'b0}}, 1'b1}) && !enabled_flag)
    else $error("disable did not remove one request");

  a_bad_ack_hold: assert property ( // RULE_20
    (ack_bad && !cmd_wr && !ctx_unblock && !ev_request && !tio_collect && !rst_all)
    |=> $stable(active_flag) && $stable(pend_count) && invalid_q)
    else $error("invalid acknowledge changed state");

  a_cc_zero: assert property ( // RULE_14
    (ev_enable || ev_disable || ev_activate || ev_deactivate) |=> cc_q == cis_pkg::CC_OK)
    else $error("condition code not zero");

  a_unblock_act: assert property ( // RULE_05
    (ctx_unblock && !rst_all) |=> active_flag)
    else $error("unblocked context switch did not activate");

  a_s5_interrupts: assert property ( // RULE_01
    (state5 && poll_win && !cpu_blocked && !ctx_ack && !cmd_wr && !ctx_unblock && no_dec
     && !rst_all) |=> intr_req)
    else $error("interrupting state did not interrupt");

  a_deact_clears: assert property ( // RULE_17
    (ev_deactivate && !ctx_unblock && !ev_ack && !rst_all) |=> !active_flag)
    else $error("deactivate left channel active");

  a_ack_active: assert property ( // RULE_20
    (ev_ack && !rst_all) |=> active_flag)
    else $error("acknowledge did not activate");

  a_tio_collect: assert property ( // RULE_04
    (tio_collect && !ev_request && !ev_disable && !ev_ack && pend_nonzero && !rst_all)
    |=> pend_count == $past(pend_count) - {{(PEND_W-1){1'b0}}, 1'b1})
    else $error("test-I/O collection did not remove one status");

  a_async_req: assert property ( // RULE_09
    (async_status && !io_complete && no_dec && !rst_all && !(&pend_count))
    |=> (pend_count == $past(pend_count) + {{(PEND_W-1){1'b0}}, 1'b1}) && requesting_flag)
    else $error("asynchronous status not counted");

  c_interrupt: cover property (state5 && poll_win ##1 intr_req ##[1:4] ctx_ack);
  c_cancel: cover property (state5 ##0 ev_activate ##1 active_flag && requesting_flag);
  c_queue_two: cover property (ev_request ##[1:8] ev_request ##1 pend_count > 8'(1));
  c_unblock: cover property (ctx_unblock ##1 active_flag);
  c_collect: cover property (tio_collect && requesting_flag);

endmodule : cis_chan_intr

// File: cis_host_model.sv
// Purpose: Host processor and interrupt bus seen from one channel.
// Assumes: One clock; bench controls priority, blocking and acknowledges.
// Notes: Acknowledges only on command; a stray acknowledge is a deliberate fault.

module cis_host_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Channel side
  input wire logic intr_req,
  input wire logic poll_req,
  output logic ctx_ack,
  output logic poll_win,
  output logic cpu_blocked,
  // Scenario controls
  input wire logic hi_prio,
  input wire logic blk,
  input wire logic auto_ack,
  input wire logic stray_ack
);
  // A polling channel of higher priority always beats this one.
  assign poll_win = poll_req & ~hi_prio;
  assign cpu_blocked = blk;

  // The pulse drops after one cycle so a stale request is never acknowledged twice.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctx_ack <= 1'b0;
    end else begin
      ctx_ack <= (auto_ack & intr_req & ~ctx_ack & ~blk) | stray_ack;
    end
  end
endmodule : cis_host_model

// File: cis_pend_cnt.sv
// Purpose: Counter of completion statuses still waiting to be posted.
// Assumes: Increment and decrement are one-cycle pulses.
// Notes: Saturates when full; a completion arriving then is dropped.

module cis_pend_cnt #(
  parameter int W = cis_pkg::PEND_W_DEF
) (
  // Clock and clear
  input wire logic core_clk,
  input wire logic clr,
  // Events
  input wire logic inc,
  input wire logic dec,
  // Count
  output logic [W-1:0] count_q,
  output logic nonzero_q
);

  localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};
  localparam logic [W-1:0] ZERO = {W{1'b0}};

  logic [W-1:0] count_d;

  always_comb begin
    count_d = count_q;
    if (clr) begin
      count_d = ZERO;
    end else if (inc && !dec && !(&count_q)) begin
      count_d = count_q + ONE;
    end else if (dec && !inc && (count_q != ZERO)) begin
      count_d = count_q - ONE;
    end
  end

  always_ff @(posedge core_clk) begin
    count_q <= count_d;
  end

  always_ff @(posedge core_clk) begin
    nonzero_q <= (count_d != ZERO);
  end

endmodule : cis_pend_cnt

// File: cis_pkg.sv
// Purpose: Shared constants for the channel interrupt state logic.
// Assumes: One clock, synchronous active-high resets.
// Notes: Register offsets are byte addresses on a 32-bit AHB-Lite slave.

package cis_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CLEAR = 8'h08;

  // ****************************************************************
  // Instruction codes written to the command register
  // ****************************************************************
  localparam logic [2:0] INSTR_NONE = 3'h0;
  localparam logic [2:0] INSTR_ENABLE = 3'h1;
  localparam logic [2:0] INSTR_DISABLE = 3'h2;
  localparam logic [2:0] INSTR_ACTIVATE = 3'h3;
  localparam logic [2:0] INSTR_DEACTIVATE = 3'h4;

  // ****************************************************************
  // Status register field positions
  // ****************************************************************
  localparam int ST_ACTIVE = 0;
  localparam int ST_ENABLED = 1;
  localparam int ST_REQUESTING = 2;
  localparam int ST_POLL = 3;
  localparam int ST_INTR = 4;
  localparam int ST_STATE_LO = 5;
  localparam int ST_CC_LO = 8;
  localparam int ST_INVALID = 12;
  localparam int ST_COUNT_LO = 16;

  // ****************************************************************
  // Values and reset values
  // ****************************************************************
  localparam logic [3:0] CC_OK = 4'h0;
  localparam logic [3:0] CC_RST = 4'hf;
  localparam logic [2:0] STATE_INTR = 3'h5;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  localparam int PEND_W_DEF = 8;

  // State number is enabled, active, requesting from high bit to low.
  function automatic logic [2:0] state_num(input logic en, input logic act, input logic req);
    state_num = {en, act, req};
  endfunction : state_num

endpackage : cis_pkg

// File: tb.sv
// Purpose: Self-checking bench of the channel interrupt state logic.
// Assumes: Zero-wait AHB-Lite slave; event inputs pulse for one cycle.
// Notes: Outputs are sampled on the falling edge, where they are settled.

module tb;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************************
  // Signals
  // ****************************************************************
  localparam logic [7:0] EV_DONE = 8'h01, EV_RSTOP = 8'h02, EV_ASYNC = 8'h04, EV_TIO = 8'h08;
  localparam logic [7:0] EV_UNBLK = 8'h10, EV_CHAN = 8'h20, EV_BUS = 8'h40, EV_STRAY = 8'h80;
  logic core_clk, sys_rst, hsel, hwrite, hi_prio, blk, auto_ack, inv_e;
  logic [31:0] haddr, hwdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] ev;
  logic [3:0] cc_e;
  wire logic hready, hresp, poll_req, intr_req, act_f, en_f, req_f, ctx_ack, poll_win, cpu_blk;
  wire logic [31:0] hrdata;
  int failures, n_checks, cyc;

  cis_chan_intr #(.PEND_W(8)) dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .chan_rst(ev[5]),
    .bus_rst(ev[6]), .io_complete(ev[0]), .io_rst_op(ev[1]), .async_status(ev[2]),
    .tio_collect(ev[3]), .ctx_ack(ctx_ack), .ctx_unblock(ev[4]), .cpu_blocked(cpu_blk),
    .poll_win(poll_win), .poll_req(poll_req), .intr_req(intr_req), .active_flag(act_f),
    .enabled_flag(en_f), .requesting_flag(req_f));

  cis_host_model host_u (.core_clk(core_clk), .sys_rst(sys_rst), .intr_req(intr_req),
    .poll_req(poll_req), .ctx_ack(ctx_ack), .poll_win(poll_win), .cpu_blocked(cpu_blk),
    .hi_prio(hi_prio), .blk(blk), .auto_ack(auto_ack), .stray_ack(ev[7]));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // The master holds each phase until hready is seen high at the falling edge before a rising edge.
  task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] wd,
                      output logic [31:0] rd);
    logic r;
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do begin
      @(negedge core_clk);
      r = hready;
      @(posedge core_clk);
    end while (r !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(negedge core_clk);
      r = hready;
      rd = hrdata;
      chk({31'h0, hresp}, 32'h0);
      @(posedge core_clk);
    end while (r !== 1'b1);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(a, 1'b1, d, x);
  endtask : wr

  task automatic cmd(input logic [2:0] c);
    wr(cis_pkg::ADDR_CMD, {29'h0, c});
    cc_e = cis_pkg::CC_OK;
  endtask : cmd

  task automatic pulse(input logic [7:0] m);
    @(posedge core_clk);
    ev <= m;
    @(posedge core_clk);
    ev <= 8'h00;
  endtask : pulse

  // Reads the status word and the flag pins against one expected state.
  task automatic st(input logic a, e, r, input logic [7:0] n, input logic p, i);
    logic [31:0] s;
    xfer(cis_pkg::ADDR_STATUS, 1'b0, 32'h0, s);
    chk(s, {8'h0, n, 3'h0, inv_e, cc_e, e, a, r, i, p, r, e, a});
    @(negedge core_clk);
    chk({27'h0, poll_req, intr_req, req_f, en_f, act_f}, {27'h0, p, i, r, e, a});
  endtask : st

  // ****************************************************************
  // Clock, timeout and tests
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // The whole run needs well under a thousand cycles.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      wrap_up();
    end
  end

  initial begin
    logic [31:0] d;
    int k;
    {sys_rst, hsel, hwrite, hi_prio, blk, auto_ack, inv_e} = 7'h40;
    {haddr, hwdata, htrans, ev} = '0;
    hsize = 3'h2;
    cc_e = cis_pkg::CC_RST;
    {failures, n_checks, cyc} = '0;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    st(0, 0, 0, 8'h0, 0, 0);
    xfer(8'h0c, 1'b0, 32'h0, d);
    chk(d, 32'h0);
    xfer(cis_pkg::ADDR_CMD, 1'b0, 32'h0, d);
    chk(d, 32'h0);
    wr(8'h0c, 32'hffff_ffff);
    st(0, 0, 0, 8'h0, 0, 0);
    $display("test 1 finished");
    pulse(EV_DONE | EV_RSTOP);
    st(0, 0, 0, 8'h0, 0, 0);
    pulse(EV_ASYNC);
    st(0, 0, 1, 8'h1, 0, 0);
    for (k = 0; k < 3; k++) begin
      pulse(EV_DONE);
    end
    st(0, 0, 1, 8'h4, 0, 0);
    cmd(cis_pkg::INSTR_DISABLE);
    st(0, 0, 1, 8'h3, 0, 0);
    pulse(EV_TIO);
    st(0, 0, 1, 8'h2, 0, 0);
    $display("test 2 finished");
    cmd(cis_pkg::INSTR_ACTIVATE);
    st(1, 0, 1, 8'h2, 1, 0);
    cmd(cis_pkg::INSTR_ENABLE);
    st(1, 1, 1, 8'h2, 1, 0);
    @(posedge core_clk);
    blk <= 1'b1;
    cmd(cis_pkg::INSTR_DEACTIVATE);
    st(0, 1, 1, 8'h2, 1, 0);
    @(posedge core_clk);
    blk <= 1'b0;
    st(0, 1, 1, 8'h2, 1, 1);
    $display("test 3 finished");
    @(posedge core_clk);
    auto_ack <= 1'b1;
    for (k = 0; k < 50 && ctx_ack !== 1'b1; k++) begin
      @(negedge core_clk);
    end
    @(posedge core_clk);
    auto_ack <= 1'b0;
    st(1, 1, 1, 8'h1, 1, 0);
    pulse(EV_STRAY);
    inv_e = 1'b1;
    st(1, 1, 1, 8'h1, 1, 0);
    wr(cis_pkg::ADDR_CLEAR, 32'h1);
    inv_e = 1'b0;
    st(1, 1, 1, 8'h1, 1, 0);
    $display("test 4 finished");
    @(posedge core_clk);
    hi_prio <= 1'b1;
    cmd(cis_pkg::INSTR_DEACTIVATE);
    st(0, 1, 1, 8'h1, 1, 0);
    cmd(cis_pkg::INSTR_ACTIVATE);
    @(posedge core_clk);
    hi_prio <= 1'b0;
    st(1, 1, 1, 8'h1, 1, 0);
    @(posedge core_clk);
    hi_prio <= 1'b1;
    cmd(cis_pkg::INSTR_DEACTIVATE);
    cmd(cis_pkg::INSTR_DISABLE);
    st(0, 0, 0, 8'h0, 0, 0);
    cmd(cis_pkg::INSTR_ENABLE);
    st(0, 1, 0, 8'h0, 0, 0);
    @(posedge core_clk);
    hi_prio <= 1'b0;
    pulse(EV_UNBLK);
    st(1, 1, 0, 8'h0, 1, 0);
    $display("test 5 finished");
    for (k = 0; k < 2; k++) begin
      cmd(cis_pkg::INSTR_ENABLE);
      cmd(cis_pkg::INSTR_ACTIVATE);
      pulse(EV_DONE);
      pulse(k == 0 ? EV_CHAN : EV_BUS);
      st(0, 0, 0, 8'h0, 0, 0);
    end
    $display("test 6 finished");
    wrap_up();
  end
endmodule : tb
